// ### bench/rcl_config_checker.sv
module rcl_config_checker
    import rcl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [1:0] channel_run_pin,
    input wire logic ext_sync_clk_present,
    input wire logic [6:0] probe_addr,
    input wire logic addr_hit,
    input wire logic [6:0] bus_addr,
    input wire logic [15:0] vout_cmd_0,
    input wire logic [15:0] freq_khz,
    input wire logic [1:0] chan_enable,
    input wire logic pwm_start_allow,
    input wire logic cfg_loaded
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    logic rst_hold_reg;
    // reset is released on an edge, so checks stay off for one more cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_hold_reg <= 1'b1;
        end else begin
            rst_hold_reg <= 1'b0;
        end
    end
    default disable iff (rst || rst_hold_reg);
    // address match is registered, so the three address checks look one cycle later
    property p_hit_global;
        probe_addr == GLOBAL_ADDR_A || probe_addr == GLOBAL_ADDR_B |=> addr_hit;
    endproperty
    a_hit_global: assert property (p_hit_global) else $error("global address missed");
    property p_hit_own;
        probe_addr == bus_addr |=> addr_hit;
    endproperty
    a_hit_own: assert property (p_hit_own) else $error("own address missed");
    property p_miss;
        probe_addr != bus_addr && probe_addr != GLOBAL_ADDR_A && probe_addr != GLOBAL_ADDR_B
            |=> !addr_hit;
    endproperty
    a_miss: assert property (p_miss) else $error("foreign address answered");
    // stored-value writes are not excluded: their change shows on bus_addr and freq_khz two cycles after the access, the first cycle the bus-idle guard passes
    property p_pins_ignored;
        cfg_loaded && $past(cfg_loaded, 3) && !psel && !$past(psel)
            |-> $stable(bus_addr) && $stable(freq_khz);
    endproperty
    a_pins_ignored: assert property (p_pins_ignored) else $error("config moved after load");
    property p_allow_cause;
        $rose(pwm_start_allow) |-> freq_khz != 16'h0000 || ext_sync_clk_present;
    endproperty
    a_allow_cause: assert property (p_allow_cause) else $error("start without clock");
    property p_chan_allow;
        chan_enable != 2'b00 |-> $past(pwm_start_allow);
    endproperty
    a_chan_allow: assert property (p_chan_allow) else $error("channel on before allow");
    property p_chan_run;
        chan_enable[1] |-> $past(channel_run_pin[1], 3);
    endproperty
    a_chan_run: assert property (p_chan_run) else $error("channel on without run");
    property p_load_out;
        $rose(cfg_loaded) |=> vout_cmd_0 != 16'h0000 && bus_addr != 7'h00;
    endproperty
    a_load_out: assert property (p_load_out) else $error("load left outputs empty");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase not ready");
    c_load: cover property ($rose(cfg_loaded));
    c_hit: cover property (addr_hit);
    c_ext: cover property ($rose(pwm_start_allow) && freq_khz == 16'h0000);
endmodule : rcl_config_checker

bind rcl_config_loader rcl_config_checker u_chk (.clk, .rst, .psel, .penable, .pready,
    .channel_run_pin, .ext_sync_clk_present, .probe_addr, .addr_hit, .bus_addr, .vout_cmd_0,
    .freq_khz, .chan_enable, .pwm_start_allow, .cfg_loaded);

// ### bench/rcl_far_side_model.sv
module rcl_far_side_model (
    input wire logic clk,
    output logic [5:0][7:0] ratio,
    output logic [1:0] run,
    output logic sync_clk,
    output logic t_valid,
    output logic t_chan,
    output logic [15:0] t_code
);
    timeunit 1ns;
    timeprecision 100ps;
    // divider levels are static; the bench sets them before each reset or reload
    initial begin
        run = 2'b11;
        sync_clk = 1'b0;
        t_valid = 1'b0;
        t_chan = 1'b0;
        t_code = 16'h0000;
    end
    // one converter result, single-cycle strobe
    task automatic temp(input logic c, input logic [15:0] code);
        @(posedge clk);
        t_valid <= 1'b1;
        t_chan <= c;
        t_code <= code;
        @(posedge clk);
        t_valid <= 1'b0;
        t_code <= ~code;
    endtask : temp
endmodule : rcl_far_side_model

// ### bench/tb_top.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
    import rcl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, addr_hit, sync_out_enable, pwm_start_allow, cfg_loaded;
    logic [6:0] probe_addr = 7'h00, bus_addr;
    logic [15:0] vout_cmd_0, vout_cmd_1, freq_khz, t_code;
    logic [8:0] phase0_deg, phase1_deg;
    logic [1:0] chan_enable, run;
    logic [5:0][7:0] ratio;
    logic sync_clk, t_valid, t_chan;
    int n_fail = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    rcl_far_side_model far (.clk, .ratio, .run, .sync_clk, .t_valid, .t_chan, .t_code);
    rcl_config_loader uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .out_voltage_divider_pin_0(ratio[0]),
        .out_voltage_divider_pin_1(ratio[1]), .switch_freq_divider_pin(ratio[2]),
        .phase_divider_pin(ratio[3]), .addr_low_divider_pin(ratio[4]),
        .addr_high_divider_pin(ratio[5]), .channel_run_pin(run), .ext_sync_clk_present(sync_clk),
        .adc_temp_valid(t_valid), .adc_temp_chan(t_chan), .adc_temp_code(t_code), .probe_addr,
        .addr_hit, .bus_addr, .vout_cmd_0, .vout_cmd_1, .freq_khz, .phase0_deg, .phase1_deg,
        .sync_out_enable, .chan_enable, .pwm_start_allow, .cfg_loaded);
    // one bus cycle; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK({err, rd}, {1'b0, e})
    endtask : rdc
    task automatic probe(input logic [6:0] a, input logic e);
        probe_addr <= a;
        repeat (2) @(posedge clk);
        `CHK(addr_hit, e)
    endtask : probe
    // the settle interval is fixed, so a bounded poll on the load flag is enough
    task automatic load_wait;
        int i;
        i = 0;
        repeat (4) @(posedge clk);
        while (cfg_loaded !== 1'b1 && i < 1000) begin
            @(posedge clk);
            i++;
        end
        repeat (6) @(posedge clk);
    endtask : load_wait
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("BAD %0t timeout", $time);
        close_out();
    end
    initial begin
        // sync output kept on by this single device only
        far.ratio = {8'h4a, 8'ha8, 8'h3f, 8'h73, 8'h00, 8'ha8};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        load_wait();
        `CHK(vout_cmd_0, 16'h1388)
        `CHK(vout_cmd_1, 16'h03e8)
        `CHK(freq_khz, 16'h04e2)
        `CHK({phase0_deg, phase1_deg, sync_out_enable}, {9'h000, 9'h0b4, 1'b1})
        `CHK(bus_addr, 7'h7f)
        `CHK(chan_enable, 2'b01)
        rdc(A_LIMITS, 32'h1194157c);
        apb(1'b1, A_OPERATION, 32'h3);
        repeat (5) @(posedge clk);
        `CHK(chan_enable, 2'b11)
        probe(7'h7f, 1'b1);
        probe(7'h5a, 1'b1);
        probe(7'h5b, 1'b1);
        probe(7'h5c, 1'b0);
        far.ratio[2] <= 8'h08;
        repeat (20) @(posedge clk);
        `CHK(freq_khz, 16'h04e2)
        // reload with stored vout, external clock only, high address part from pin
        far.ratio <= {8'h08, 8'hff, 8'h3f, 8'h00, 8'h00, 8'hff};
        apb(1'b1, A_RESET_CMD, 32'h1);
        load_wait();
        `CHK(vout_cmd_0, 16'h03e8)
        `CHK(freq_khz, 16'h0000)
        `CHK(bus_addr, 7'h10)
        `CHK(pwm_start_allow, 1'b0)
        rdc(A_LIMITS, 32'h0384044c);
        far.sync_clk <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(pwm_start_allow, 1'b1)
        far.ratio[5] <= 8'hff;
        far.sync_clk <= 1'b0;
        apb(1'b1, A_RESET_CMD, 32'h1);
        load_wait();
        `CHK(bus_addr, 7'h40)
        far.temp(1'b0, 16'h2000);
        rdc(A_TEMP, 32'h00000eee);
        apb(1'b1, A_PWM_MODE, 32'h20);
        apb(1'b1, A_SLOPE, 32'h2000);
        apb(1'b1, A_OFFSET, 32'h10);
        apb(1'b1, A_PAGE, 32'h1);
        far.temp(1'b1, 16'h2000);
        rdc(A_TEMP, 32'h00001010);
        apb(1'b0, 8'hfc, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        close_out();
    end
endmodule : tb_top

// ### rtl/rcl_band_quant.sv
// synchronises one digitised divider ratio and sorts it into a band
module rcl_band_quant
    import rcl_pkg::*;
#(
    parameter int W = RATIO_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] ratio,
    output logic [BAND_W-1:0] band,
    output logic fallback
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [BAND_W-1:0] band;
        logic fb;
    } rcl_quant_s;

    rcl_quant_s q_reg;
    rcl_quant_s q_next;

    // the ratio is quasi-static while sampled, so a plain two-flop bus sync is enough
    always_comb begin
        q_next = q_reg;
        q_next.s1 = ratio;
        q_next.s2 = q_reg.s1;
        q_next.band = '0;
        for (int i = 0; i < NUM_EDGES; i++) begin
            if (q_reg.s2 >= BAND_EDGE[i]) begin
                q_next.band = BAND_W'(i + 1);
            end
        end
        q_next.fb = (q_reg.s2 >= FALLBACK_EDGE);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign band = q_reg.band;
    assign fallback = q_reg.fb;
endmodule : rcl_band_quant

// ### rtl/rcl_config_loader.sv
// divider-pin configuration loader with external temperature scaling
//
// The APB slave port and the register addresses are this design's own decisions.
module rcl_config_loader
    import rcl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [RATIO_W-1:0] out_voltage_divider_pin_0,
    input wire logic [RATIO_W-1:0] out_voltage_divider_pin_1,
    input wire logic [RATIO_W-1:0] switch_freq_divider_pin,
    input wire logic [RATIO_W-1:0] phase_divider_pin,
    input wire logic [RATIO_W-1:0] addr_low_divider_pin,
    input wire logic [RATIO_W-1:0] addr_high_divider_pin,
    input wire logic [1:0] channel_run_pin,
    input wire logic ext_sync_clk_present,
    input wire logic adc_temp_valid,
    input wire logic adc_temp_chan,
    input wire logic [15:0] adc_temp_code,
    input wire logic [6:0] probe_addr,
    output logic addr_hit,
    output logic [6:0] bus_addr,
    output logic [15:0] vout_cmd_0,
    output logic [15:0] vout_cmd_1,
    output logic [15:0] freq_khz,
    output logic [8:0] phase0_deg,
    output logic [8:0] phase1_deg,
    output logic sync_out_enable,
    output logic [1:0] chan_enable,
    output logic pwm_start_allow,
    output logic cfg_loaded
);
    localparam int NPIN = 6;
    localparam int P_V0 = 0;
    localparam int P_V1 = 1;
    localparam int P_FRQ = 2;
    localparam int P_PHS = 3;
    localparam int P_ALO = 4;
    localparam int P_AHI = 5;

    typedef struct packed {
        rcl_state_e state;
        logic [CNT_W-1:0] cnt;
        logic loaded;
        logic [7:0] pwm_mode_config;
        logic page;
        logic [1:0] operation;
        logic [15:0] ext_temp_slope_coeff;
        logic [15:0] ext_temp_offset_param;
        logic [6:0] stored_device_addr;
        logic [1:0][15:0] stored_vout;
        logic [15:0] stored_freq;
        logic [3:0] stored_phase;
        logic [NPIN-1:0][BAND_W-1:0] band;
        logic [NPIN-1:0] fb;
        logic [1:0][15:0] ov;
        logic [1:0][15:0] uv;
        logic [1:0][15:0] temp;
        logic [1:0] run_s1;
        logic [1:0] run_s2;
        logic sync_s1;
        logic sync_s2;
        logic ext_seen;
        logic [31:0] prdata;
        logic addr_hit;
        logic [6:0] addr;
        logic [1:0][15:0] vout;
        logic [15:0] freq;
        rcl_phase_s phase;
        logic [1:0] chan_en;
        logic allow;
    } rcl_ctl_s;

    rcl_ctl_s r_reg;
    rcl_ctl_s r_next;

    logic [NPIN-1:0][RATIO_W-1:0] pin_ratio;
    logic [NPIN-1:0][BAND_W-1:0] q_band;
    logic [NPIN-1:0] q_fb;

    assign pin_ratio[P_V0] = out_voltage_divider_pin_0;
    assign pin_ratio[P_V1] = out_voltage_divider_pin_1;
    assign pin_ratio[P_FRQ] = switch_freq_divider_pin;
    assign pin_ratio[P_PHS] = phase_divider_pin;
    assign pin_ratio[P_ALO] = addr_low_divider_pin;
    assign pin_ratio[P_AHI] = addr_high_divider_pin;

    // one quantizer per divider pin
    for (genvar g = 0; g < NPIN; g++) begin : g_quant
        rcl_band_quant #(
            .W(RATIO_W)
        ) u_quant (
            .clk(clk),
            .rst(rst),
            .ratio(pin_ratio[g]),
            .band(q_band[g]),
            .fallback(q_fb[g])
        );
    end

    function automatic logic addr_valid(input logic [7:0] a);
        case (a)
            A_PWM_MODE, A_PAGE, A_OPERATION, A_RESET_CMD, A_SLOPE, A_OFFSET,
            A_STORED_ADDR, A_STORED_VOUT, A_STORED_FREQ, A_STORED_PHASE,
            A_VOUT_CMD, A_LIMITS, A_FREQ, A_PHASE, A_ADDR, A_TEMP, A_STATUS: addr_valid = 1'b1;
            default: addr_valid = 1'b0;
        endcase
    endfunction : addr_valid

    function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [7:0] p);
        logic [23:0] prod;
        prod = v * p;
        pct_of = 16'(prod / PCT_DIV);
    endfunction : pct_of

    logic wr_en;
    logic rd_setup;
    logic reload;
    logic [31:0] prod;
    logic [15:0] scaled;
    logic ext_only;
    logic [3:0] phase_code;
    logic [1:0] pin_vout;

    assign wr_en = psel && penable && pwrite && addr_valid(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign reload = wr_en && (paddr == A_RESET_CMD) && pwdata[0];

    // whole next state: bus writes, pin sampling, outputs and temperature
    always_comb begin
        r_next = r_reg;
        prod = adc_temp_code * r_reg.ext_temp_slope_coeff;
        scaled = prod[GAIN_FRAC +: 16];
        ext_only = 1'b0;
        phase_code = r_reg.stored_phase;
        pin_vout = '0;

        // run and sync come from pins, so two flops before use
        r_next.run_s1 = channel_run_pin;
        r_next.run_s2 = r_reg.run_s1;
        r_next.sync_s1 = ext_sync_clk_present;
        r_next.sync_s2 = r_reg.sync_s1;

        // register writes
        if (wr_en) begin
            case (paddr)
                A_PWM_MODE: r_next.pwm_mode_config = pwdata[7:0];
                A_PAGE: r_next.page = pwdata[0];
                A_OPERATION: r_next.operation = pwdata[1:0];
                A_SLOPE: r_next.ext_temp_slope_coeff = pwdata[15:0];
                A_OFFSET: r_next.ext_temp_offset_param = pwdata[15:0];
                A_STORED_ADDR: r_next.stored_device_addr = pwdata[6:0];
                A_STORED_VOUT: r_next.stored_vout[r_reg.page] = pwdata[15:0];
                A_STORED_FREQ: r_next.stored_freq = pwdata[15:0];
                A_STORED_PHASE: r_next.stored_phase = pwdata[3:0];
                default: ;
            endcase
        end

        // load sequence: let the dividers settle, latch once, then ignore the pins
        case (r_reg.state)
            ST_SETTLE: begin
                if (r_reg.cnt == CNT_W'(SETTLE_CYC - 1)) begin
                    r_next.state = ST_LATCH;
                end else begin
                    r_next.cnt = r_reg.cnt + 1'b1;
                end
            end
            ST_LATCH: begin
                r_next.band = q_band;
                r_next.fb = q_fb;
                for (int c = 0; c < 2; c++) begin
                    // limits from an earlier pin load must not survive a stored setpoint
                    r_next.ov[c] = OV_RST;
                    r_next.uv[c] = UV_RST;
                    if (!q_fb[c] && q_band[c] == BAND_OFF) begin
                        r_next.operation[c] = 1'b0;
                    end else if (!q_fb[c]) begin
                        r_next.ov[c] = pct_of(vout_of_band(q_band[c]), OV_PCT);
                        r_next.uv[c] = pct_of(vout_of_band(q_band[c]), UV_PCT);
                    end
                end
                r_next.loaded = 1'b1;
                r_next.state = ST_RUN;
            end
            ST_RUN: ;
            default: r_next.state = ST_SETTLE;
        endcase

        // a reset command restarts the load like power-up, except that ext_seen stays set if it arrives in ST_RUN with sync_s2 high
        if (reload) begin
            r_next.state = ST_SETTLE;
            r_next.cnt = '0;
            r_next.loaded = 1'b0;
            r_next.ext_seen = 1'b0;
        end

        // active setpoints: table entry, or the stored value on fallback, vout band 0 or a band above the table
        for (int c = 0; c < 2; c++) begin
            pin_vout[c] = !r_reg.fb[c] && (r_reg.band[c] != BAND_OFF);
            r_next.vout[c] = pin_vout[c] ? vout_of_band(r_reg.band[c]) : r_reg.stored_vout[c];
        end
        if (!r_reg.fb[P_FRQ] && r_reg.band[P_FRQ] <= FREQ_MAX_BAND) begin
            r_next.freq = freq_of_band(r_reg.band[P_FRQ]);
        end else begin
            r_next.freq = r_reg.stored_freq;
        end
        if (!r_reg.fb[P_PHS] && r_reg.band[P_PHS] <= PHASE_MAX_BAND) begin
            phase_code = r_reg.band[P_PHS];
        end
        r_next.phase = phase_of_band(phase_code);

        // address halves, each from its pin or from the stored value
        r_next.addr[3:0] = r_reg.fb[P_ALO] ? r_reg.stored_device_addr[3:0]
                                           : r_reg.band[P_ALO];
        if (r_reg.fb[P_AHI] || r_reg.band[P_AHI] > AHI_MAX_BAND) begin
            r_next.addr[6:4] = r_reg.stored_device_addr[6:4];
        end else begin
            r_next.addr[6:4] = r_reg.band[P_AHI][2:0];
        end
        r_next.addr_hit = (probe_addr == r_reg.addr) || (probe_addr == GLOBAL_ADDR_A)
                          || (probe_addr == GLOBAL_ADDR_B);

        // external-only clocking holds the outputs until a sync clock shows up
        ext_only = (r_next.freq == 16'h0000); // next value: stale freq leaks a start pulse
        if (r_reg.state == ST_RUN && r_reg.sync_s2) begin
            r_next.ext_seen = 1'b1;
        end
        r_next.allow = r_reg.loaded && (!ext_only || r_reg.ext_seen);
        r_next.chan_en = (r_reg.allow ? 2'b11 : 2'b00) & r_reg.operation & r_reg.run_s2;

        // temperature: slope applies to both methods, offset base differs
        if (adc_temp_valid) begin
            if (r_reg.pwm_mode_config[TEMP_MODE_BIT]) begin
                r_next.temp[adc_temp_chan] = scaled + r_reg.ext_temp_offset_param;
            end else begin
                r_next.temp[adc_temp_chan] = scaled + r_reg.ext_temp_offset_param
                                             - KELVIN_OFS;
            end
        end

        // read data is captured in the setup cycle so prdata leaves a flop
        if (rd_setup) begin
            case (paddr)
                A_PWM_MODE: r_next.prdata = {24'h000000, r_reg.pwm_mode_config};
                A_PAGE: r_next.prdata = {31'h00000000, r_reg.page};
                A_OPERATION: r_next.prdata = {30'h00000000, r_reg.operation};
                A_SLOPE: r_next.prdata = {16'h0000, r_reg.ext_temp_slope_coeff};
                A_OFFSET: r_next.prdata = {16'h0000, r_reg.ext_temp_offset_param};
                A_STORED_ADDR: r_next.prdata = {25'h0000000, r_reg.stored_device_addr};
                A_STORED_VOUT: r_next.prdata = {16'h0000, r_reg.stored_vout[r_reg.page]};
                A_STORED_FREQ: r_next.prdata = {16'h0000, r_reg.stored_freq};
                A_STORED_PHASE: r_next.prdata = {28'h0000000, r_reg.stored_phase};
                A_VOUT_CMD: r_next.prdata = {16'h0000, r_reg.vout[r_reg.page]};
                A_LIMITS: r_next.prdata = {r_reg.uv[r_reg.page], r_reg.ov[r_reg.page]};
                A_FREQ: r_next.prdata = {16'h0000, r_reg.freq};
                A_PHASE: r_next.prdata = {12'h000, r_reg.phase};
                A_ADDR: r_next.prdata = {25'h0000000, r_reg.addr};
                A_TEMP: r_next.prdata = {16'h0000, r_reg.temp[r_reg.page]};
                A_STATUS: r_next.prdata = {26'h0000000, r_reg.chan_en, ext_only,
                                           r_reg.ext_seen, r_reg.allow, r_reg.loaded};
                default: r_next.prdata = 32'h00000000;
            endcase
        end
    end

    // single register stage for all control state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.state <= ST_SETTLE;
            r_reg.pwm_mode_config <= PWM_MODE_RST;
            r_reg.operation <= OPERATION_RST;
            r_reg.ext_temp_slope_coeff <= SLOPE_RST;
            r_reg.ext_temp_offset_param <= OFFSET_RST;
            r_reg.stored_device_addr <= STORED_ADDR_RST;
            r_reg.stored_vout <= {STORED_VOUT_RST, STORED_VOUT_RST};
            r_reg.stored_freq <= STORED_FREQ_RST;
            r_reg.stored_phase <= STORED_PHASE_RST;
            r_reg.fb <= '1;
            r_reg.ov <= {OV_RST, OV_RST};
            r_reg.uv <= {UV_RST, UV_RST};
        end else begin
            r_reg <= r_next;
        end
    end

    // zero-wait slave: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_valid(paddr);
    assign prdata = r_reg.prdata;
    assign addr_hit = r_reg.addr_hit;
    assign bus_addr = r_reg.addr;
    assign vout_cmd_0 = r_reg.vout[0];
    assign vout_cmd_1 = r_reg.vout[1];
    assign freq_khz = r_reg.freq;
    assign phase0_deg = r_reg.phase.phase0;
    assign phase1_deg = r_reg.phase.phase1;
    assign sync_out_enable = !r_reg.phase.sync_dis;
    assign chan_enable = r_reg.chan_en;
    assign pwm_start_allow = r_reg.allow;
    assign cfg_loaded = r_reg.loaded;
endmodule : rcl_config_loader

// ### rtl/rcl_pkg.sv
package rcl_pkg;
    // timing
    localparam int CLK_MHZ = 40;
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int CNT_W = 16;

    // divider quantizer: fifteen band edges ascending, plus the fallback edge
    localparam int RATIO_W = 8;
    localparam int BAND_W = 4;
    localparam int NUM_EDGES = 15;
    localparam logic [NUM_EDGES-1:0][7:0] BAND_EDGE = {8'ha8, 8'h96, 8'h8a, 8'h7e, 8'h73,
        8'h68, 8'h5f, 8'h55, 8'h4a, 8'h3f, 8'h35, 8'h2b, 8'h20, 8'h15, 8'h08};
    localparam logic [7:0] FALLBACK_EDGE = 8'hd9;
    localparam logic [3:0] BAND_OFF = 4'h0;
    localparam logic [3:0] FREQ_MAX_BAND = 4'hb;
    localparam logic [3:0] PHASE_MAX_BAND = 4'ha;
    localparam logic [3:0] AHI_MAX_BAND = 4'h7;

    // register byte offsets
    localparam logic [7:0] A_PWM_MODE = 8'h00;
    localparam logic [7:0] A_PAGE = 8'h04;
    localparam logic [7:0] A_OPERATION = 8'h08;
    localparam logic [7:0] A_RESET_CMD = 8'h0c;
    localparam logic [7:0] A_SLOPE = 8'h10;
    localparam logic [7:0] A_OFFSET = 8'h14;
    localparam logic [7:0] A_STORED_ADDR = 8'h18;
    localparam logic [7:0] A_STORED_VOUT = 8'h1c;
    localparam logic [7:0] A_STORED_FREQ = 8'h20;
    localparam logic [7:0] A_STORED_PHASE = 8'h24;
    localparam logic [7:0] A_VOUT_CMD = 8'h28;
    localparam logic [7:0] A_LIMITS = 8'h2c;
    localparam logic [7:0] A_FREQ = 8'h30;
    localparam logic [7:0] A_PHASE = 8'h34;
    localparam logic [7:0] A_ADDR = 8'h38;
    localparam logic [7:0] A_TEMP = 8'h3c;
    localparam logic [7:0] A_STATUS = 8'h40;

    // fields and reset values
    localparam int TEMP_MODE_BIT = 5;
    localparam logic [7:0] PWM_MODE_RST = 8'h00;
    localparam logic [1:0] OPERATION_RST = 2'h3;
    localparam logic [15:0] SLOPE_RST = 16'h4000;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [6:0] STORED_ADDR_RST = 7'h40;
    localparam logic [15:0] STORED_VOUT_RST = 16'h03e8;
    localparam logic [15:0] STORED_FREQ_RST = 16'h01f4;
    localparam logic [3:0] STORED_PHASE_RST = 4'h6;
    localparam logic [15:0] OV_RST = 16'h044c;
    localparam logic [15:0] UV_RST = 16'h0384;

    // temperature arithmetic: slope is 2.14 fixed point, temperature in 1/16 degree
    localparam int GAIN_FRAC = 14;
    localparam logic [15:0] KELVIN_OFS = 16'h1112;

    // derived limits as percent of the setpoint
    localparam logic [7:0] OV_PCT = 8'h6e;
    localparam logic [7:0] UV_PCT = 8'h5a;
    localparam logic [23:0] PCT_DIV = 24'h000064;

    // global bus addresses
    localparam logic [6:0] GLOBAL_ADDR_A = 7'h5a;
    localparam logic [6:0] GLOBAL_ADDR_B = 7'h5b;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_LATCH = 2'b01,
        ST_RUN = 2'b10
    } rcl_state_e;

    typedef struct packed {
        logic [8:0] phase0;
        logic [8:0] phase1;
        logic sync_dis;
        logic duty_low;
    } rcl_phase_s;

    // setpoint in mV for a vout band; band 0 carries no setpoint
    function automatic logic [15:0] vout_of_band(input logic [3:0] b);
        case (b)
            4'hf: vout_of_band = 16'h1388;
            4'he: vout_of_band = 16'h0ce4;
            4'hd: vout_of_band = 16'h09c4;
            4'hc: vout_of_band = 16'h0708;
            4'hb: vout_of_band = 16'h05dc;
            4'ha: vout_of_band = 16'h0546;
            4'h9: vout_of_band = 16'h04e2;
            4'h8: vout_of_band = 16'h04b0;
            4'h7: vout_of_band = 16'h047e;
            4'h6: vout_of_band = 16'h044c;
            4'h5: vout_of_band = 16'h041a;
            4'h4: vout_of_band = 16'h0384;
            4'h3: vout_of_band = 16'h02ee;
            4'h2: vout_of_band = 16'h028a;
            4'h1: vout_of_band = 16'h0258;
            default: vout_of_band = 16'h0000;
        endcase
    endfunction : vout_of_band

    // frequency in kHz; band 0 is external clock only
    function automatic logic [15:0] freq_of_band(input logic [3:0] b);
        case (b)
            4'hb: freq_of_band = 16'h04e2;
            4'ha: freq_of_band = 16'h03e8;
            4'h9: freq_of_band = 16'h0384;
            4'h8: freq_of_band = 16'h02ee;
            4'h7: freq_of_band = 16'h0258;
            4'h6: freq_of_band = 16'h01f4;
            4'h5: freq_of_band = 16'h01c2;
            4'h4: freq_of_band = 16'h0190;
            4'h3: freq_of_band = 16'h015e;
            4'h2: freq_of_band = 16'h012c;
            4'h1: freq_of_band = 16'h00fa;
            default: freq_of_band = 16'h0000;
        endcase
    endfunction : freq_of_band

    // phase offsets, sync output disable and max-duty group for a phase code
    function automatic rcl_phase_s phase_of_band(input logic [3:0] b);
        case (b)
            4'ha: phase_of_band = '{9'h087, 9'h13b, 1'b1, 1'b0};
            4'h9: phase_of_band = '{9'h05a, 9'h10e, 1'b1, 1'b0};
            4'h8: phase_of_band = '{9'h02d, 9'h0e1, 1'b1, 1'b0};
            4'h7: phase_of_band = '{9'h000, 9'h0b4, 1'b1, 1'b0};
            4'h6: phase_of_band = '{9'h000, 9'h0b4, 1'b0, 1'b0};
            4'h5: phase_of_band = '{9'h078, 9'h12c, 1'b1, 1'b1};
            4'h4: phase_of_band = '{9'h03c, 9'h0f0, 1'b1, 1'b1};
            4'h3: phase_of_band = '{9'h000, 9'h0b4, 1'b1, 1'b1};
            4'h2: phase_of_band = '{9'h000, 9'h078, 1'b1, 1'b1};
            4'h1: phase_of_band = '{9'h000, 9'h0b4, 1'b0, 1'b1};
            default: phase_of_band = '{9'h000, 9'h078, 1'b0, 1'b1};
        endcase
    endfunction : phase_of_band
endpackage : rcl_pkg
